/* File: fsc_fail_safe_monitor.sv */
// Fail-safe clock monitor top: clock source control, start-up timer,
// fail flag, interrupt request and the register port.
// Assumes all pins are synchronous to clock; reset, sleep and wake come
// from the device's power control as one-cycle pulses or levels.
// Reads never stall.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`include "fsc_consts.svh"
`timescale 1ns/10ps
module fsc_fail_safe_monitor (
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Pins
  input  wire logic        extClkIn,
  input  wire logic        lfOscIn,
  input  wire logic        sleepEnter,
  input  wire logic        wakeDone,
  // Register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  // Outputs
  output logic      [15:0] regRdData,
  output logic             sysClkInternal,
  output logic      [3:0]  intFreqSel,
  output logic             cpuStall,
  output logic             failSafeActive,
  output logic             oscFailIrq
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  fsc_detect_if detIf ();                       // Link to the detector

  // State

  logic              extPrev_q, extPrev_d;      // Previous external level
  fsc_pkg::fsc_word_t config_q,  config_d;      // Configuration word
  fsc_pkg::fsc_word_t control_q, control_d;     // Oscillator control
  logic              flag_q,    flag_d;         // Oscillator fail flag
  logic              irqEn_q,   irqEn_d;        // Fail interrupt enable
  fsc_pkg::fsc_state_e state_q, state_d;        // Clock controller state
  logic [9:0]        ost_q,     ost_d;          // Start-up edge count
  logic              ostDone_q, ostDone_d;      // Start-up timer expired
  logic              fsCond_q,  fsCond_d;       // Fail-safe condition
  fsc_pkg::fsc_word_t rdData_q,  rdData_d;      // Read data
  logic              sysInt_q,  sysInt_d;       // Running internal
  logic [3:0]        freq_q,    freq_d;         // Internal frequency out
  logic              stall_q,   stall_d;        // Core held in start-up
  logic              irq_q,     irq_d;          // Interrupt request

  // Helpers
  logic              extFall;                   // External falling edge
  logic              wrCtrl;                    // Control register write
  logic              selChange;                 // Clock select changed
  logic [1:0]        selNext;                   // Select after this cycle
  logic [2:0]        mode;                      // Configured mode
  logic              twoSpeed;                  // Two-speed start-up on
  logic              failEn;                    // Fail-safe enabled
  fsc_pkg::fsc_word_t statusWord;               // Live status


  // ----------------------------------------------------------------------
  // Fail detector
  // ----------------------------------------------------------------------
  // Failure detection
  fsc_fail_detector uDetect (
    .clock   (clock),
    .reset_n (reset_n),
    .det     (detIf)
  );


  // Link inputs
  assign detIf.extFall   = extFall;
  assign detIf.lfOsc     = lfOscIn;
  // Armed only while running external after start-up
  assign detIf.monitorOn = failEn && (state_q == fsc_pkg::ST_EXTERNAL);

  // ----------------------------------------------------------------------
  // Decode and edge detection
  // ----------------------------------------------------------------------
  always_comb begin
    // Pin edge
    extPrev_d  = extClkIn;
    extFall    = extPrev_q & ~extClkIn;

    // Config fields
    mode       = config_q[`FSC_CFG_MODE_MSB:`FSC_CFG_MODE_LSB];
    failEn     = config_q[`FSC_CFG_FAILSAFE];
    // Fail-safe enable forces two-speed start-up on
    twoSpeed   = failEn | config_q[`FSC_CFG_SWITCH];

    // Select on write
    wrCtrl     = regWrEn && (regAddr == `FSC_ADDR_CONTROL);
    selNext    = wrCtrl ? regWrData[`FSC_CTL_SCS_MSB:`FSC_CTL_SCS_LSB]
                        : control_q[`FSC_CTL_SCS_MSB:`FSC_CTL_SCS_LSB];
    // Rewrite is no change
    selChange  = wrCtrl &&
                 (selNext != control_q[`FSC_CTL_SCS_MSB:`FSC_CTL_SCS_LSB]);

    // Live status
    statusWord = 16'h0000;
    statusWord[`FSC_ST_OST_DONE] = ostDone_q;
    statusWord[`FSC_ST_EXTERNAL] = (state_q == fsc_pkg::ST_EXTERNAL);
    statusWord[`FSC_ST_FAILSAFE] = fsCond_q;
    statusWord[`FSC_ST_OST_RUN]  = (state_q == fsc_pkg::ST_STARTUP);
    statusWord[`FSC_ST_MONITOR]  = detIf.monitorOn;
  end


  always_ff @(posedge clock) begin
    // Idles low: no false fall
    if (!reset_n) begin
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= extPrev_d;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Mode field is only read at launch, as a fuse word would be; the fail-safe and switchover bits act at once
  always_comb begin
    // Hold
    config_d  = config_q;
    control_d = control_q;
    irqEn_d   = irqEn_q;
    flag_d    = flag_q;

    // Writes
    if (regWrEn) begin
      case (regAddr)
        `FSC_ADDR_CONFIG:  config_d  = regWrData & `FSC_CFG_MASK;
        `FSC_ADDR_CONTROL: control_d = regWrData & `FSC_CTL_MASK;
        `FSC_ADDR_FLAGS:   flag_d    = regWrData[`FSC_FLAG_OSCFAIL];
        `FSC_ADDR_ENABLES: irqEn_d   = regWrData[`FSC_EN_OSCFAIL];
        default: begin
          config_d = config_q;
        end
      endcase
    end

    // Hardware set beats a software clear in the same cycle
    if (detIf.failPulse) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    // Fuse defaults
    if (!reset_n) begin
      config_q  <= `FSC_CFG_RESET;
      control_q <= `FSC_CTL_RESET;
      irqEn_q   <= 1'b0;
      flag_q    <= 1'b0;
    end else begin
      config_q  <= config_d;
      control_q <= control_d;
      irqEn_q   <= irqEn_d;
      flag_q    <= flag_d;
    end
  end

  // ----------------------------------------------------------------------
  // Clock controller
  // ----------------------------------------------------------------------
  // Launch picks internal, direct external, or start-up timer first
  function automatic fsc_pkg::fsc_state_e launch(input logic [1:0] sel,
                                                 input logic [2:0] md);
    fsc_pkg::fsc_state_e nxt;
    // Internal: no timer
    if (sel[1]) begin
      nxt = fsc_pkg::ST_INTERNAL;
    // Secondary: timer
    end else if (sel == `FSC_SCS_SECOND) begin
      nxt = fsc_pkg::ST_STARTUP;
    end else begin

      // By mode
      case (md)
        `FSC_MODE_INTERNAL_OSC: nxt = fsc_pkg::ST_INTERNAL;
        `FSC_MODE_EC:     nxt = fsc_pkg::ST_EXTERNAL;   // No timer: monitor at once
        `FSC_MODE_RC:     nxt = fsc_pkg::ST_EXTERNAL;
        `FSC_MODE_RCIO:   nxt = fsc_pkg::ST_EXTERNAL;
        default:          nxt = fsc_pkg::ST_STARTUP;
      endcase
    end

    return nxt;
  endfunction

  always_comb begin
    // Hold
    state_d   = state_q;
    ost_d     = ost_q;
    ostDone_d = ostDone_q;
    fsCond_d  = fsCond_q;

    // Sleep first
    if (sleepEnter) begin
      // Sleep ends any fail-safe condition
      state_d  = fsc_pkg::ST_SLEEP;
      fsCond_d = 1'b0;
    end else if (selChange) begin
      // New select restarts the timer; condition stays until it succeeds
      state_d   = launch(selNext, mode);
      ost_d     = 10'h000;
      ostDone_d = 1'b0;
      // Direct relaunch
      if (state_d != fsc_pkg::ST_STARTUP) begin
        fsCond_d = fsCond_q && (state_d != fsc_pkg::ST_EXTERNAL);
      end
    end else begin
      case (state_q)

        // After reset
        fsc_pkg::ST_BOOT: begin
          state_d   = launch(selNext, mode);
          ost_d     = 10'h000;
          ostDone_d = 1'b0;
        end

        // Await wake
        fsc_pkg::ST_SLEEP: begin
          if (wakeDone) begin
            state_d   = launch(selNext, mode);
            ost_d     = 10'h000;
            ostDone_d = 1'b0;
          end
        end

        // Timer
        fsc_pkg::ST_STARTUP: begin
          if (extFall) begin
            ost_d = ost_q + `FSC_OST_STEP;
            // Last fall
            if (ost_q == `FSC_OST_LAST) begin
              // Switch made: only now is the condition lifted
              state_d   = fsc_pkg::ST_EXTERNAL;
              ostDone_d = 1'b1;
              fsCond_d  = 1'b0;
            end
          end
        end

        // Monitored
        fsc_pkg::ST_EXTERNAL: begin
          // Fail ends it
          if (detIf.failPulse) begin
            state_d  = fsc_pkg::ST_FAILSAFE;
            fsCond_d = 1'b1;
          end
        end

        // Held
        fsc_pkg::ST_FAILSAFE: begin
          state_d = fsc_pkg::ST_FAILSAFE;
        end

        // By choice
        fsc_pkg::ST_INTERNAL: begin
          state_d = fsc_pkg::ST_INTERNAL;
        end

        // Relaunch
        default: begin
          state_d = fsc_pkg::ST_BOOT;
        end
      endcase
    end
  end

  // Synchronous reset clears the condition and relaunches
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q   <= fsc_pkg::ST_BOOT;
      ost_q     <= 10'h000;
      ostDone_q <= 1'b0;
      fsCond_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      ost_q     <= ost_d;
      ostDone_q <= ostDone_d;
      fsCond_q  <= fsCond_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs and read port
  // ----------------------------------------------------------------------
  // All outputs registered; clock mux follows the next state directly
  always_comb begin
    // Source select
    sysInt_d = (state_d != fsc_pkg::ST_EXTERNAL);
    // Frequency follows the select field at all times, so it is set early
    freq_d   = control_d[`FSC_CTL_INTERNAL_FREQ_SELECT_MSB:`FSC_CTL_INTERNAL_FREQ_SELECT_LSB];
    // Without two-speed the core waits for the timer
    stall_d  = (state_d == fsc_pkg::ST_STARTUP) && !twoSpeed;
    // Level request
    irq_d    = flag_d && irqEn_d;

    // Read mux
    rdData_d = 16'h0000;
    if (regRdEn) begin
      case (regAddr)
        `FSC_ADDR_CONFIG:  rdData_d = config_q;
        `FSC_ADDR_CONTROL: rdData_d = control_q;
        `FSC_ADDR_STATUS:  rdData_d = statusWord;
        `FSC_ADDR_FLAGS:   rdData_d[`FSC_FLAG_OSCFAIL] = flag_q;
        `FSC_ADDR_ENABLES: rdData_d[`FSC_EN_OSCFAIL]   = irqEn_q;
        default:           rdData_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    // Start internal
    if (!reset_n) begin
      sysInt_q <= 1'b1;
      freq_q   <= 4'h0;
      stall_q  <= 1'b0;
      irq_q    <= 1'b0;
      rdData_q <= 16'h0000;
    end else begin
      sysInt_q <= sysInt_d;
      freq_q   <= freq_d;
      stall_q  <= stall_d;
      irq_q    <= irq_d;
      rdData_q <= rdData_d;
    end
  end

  // From flops
  assign regRdData      = rdData_q;
  assign sysClkInternal = sysInt_q;
  assign intFreqSel     = freq_q;
  assign cpuStall       = stall_q;
  assign failSafeActive = fsCond_q;
  assign oscFailIrq     = irq_q;
endmodule

/* File: fsc_consts.svh */
// Constants for the fail-safe clock monitor: register offsets, field positions,
// reset values, oscillator mode codes and divider and start-up counts.
// Assumes it is included by bare name into every file that needs a figure.
//
// Behaviour
// - Detect failure only after start-up timer expired
// - Monitor active only with fail-safe enable set
// - Monitor every external clock mode
// - Sample clock is low-frequency oscillator divided by 64
// - External falling edge sets detector latch
// - Sample clock rising edge clears detector latch
// - Fail after half sample period without edge
// - On failure switch internal, set fail flag
// - Interrupt when fail flag and enable set
// - Stay internal until firmware switches back
// - Fail-safe frequency follows internal frequency select
// - Reset, sleep or select change clears condition (a select change here clears it only once the external switch succeeds)
// - Select change restarts timer, run internal meanwhile
// - Condition clears only after successful external switch
// - Still failing after switch-back sets flag again (here only in EC, RC and RCIO; timer modes stay in start-up)
// - Timer after reset/wake, skipped in EC, RC
// - Monitor enable also enables two-speed start-up
// - Fail-safe enable bit 13, switchover bit 12
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FSC_ADDR_CONFIG   3'h0
`define FSC_ADDR_CONTROL  3'h1
`define FSC_ADDR_STATUS   3'h2
`define FSC_ADDR_FLAGS    3'h3
`define FSC_ADDR_ENABLES  3'h4

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FSC_CFG_FAILSAFE  13
`define FSC_CFG_SWITCH    12
`define FSC_CFG_MODE_MSB  2
`define FSC_CFG_MODE_LSB  0
`define FSC_CFG_MASK      16'h3FFF
`define FSC_CFG_RESET     16'h3002
`define FSC_CTL_SCS_MSB   1
`define FSC_CTL_SCS_LSB   0
`define FSC_CTL_INTERNAL_FREQ_SELECT_MSB  6
`define FSC_CTL_INTERNAL_FREQ_SELECT_LSB  3
`define FSC_CTL_MASK      16'h007F
`define FSC_CTL_RESET     16'h0000
`define FSC_ST_OST_DONE   0
`define FSC_ST_EXTERNAL   1
`define FSC_ST_FAILSAFE   2
`define FSC_ST_OST_RUN    3
`define FSC_ST_MONITOR    4
`define FSC_FLAG_OSCFAIL  7
`define FSC_EN_OSCFAIL    7

// ----------------------------------------------------------------------
// Oscillator mode and clock select codes
// ----------------------------------------------------------------------
`define FSC_MODE_LP       3'h0
`define FSC_MODE_XT       3'h1
`define FSC_MODE_HS       3'h2
`define FSC_MODE_EC       3'h3
`define FSC_MODE_INTERNAL_OSC   3'h4
`define FSC_MODE_SECOND   3'h5
`define FSC_MODE_RC       3'h6
`define FSC_MODE_RCIO     3'h7
`define FSC_SCS_CONFIG    2'h0
`define FSC_SCS_SECOND    2'h1

// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define FSC_DIV_HALF      6'h1F
`define FSC_DIV_LAST      6'h3F
`define FSC_DIV_STEP      6'h01
`define FSC_OST_LAST      10'h3FF
`define FSC_OST_STEP      10'h001

`endif

/* File: fsc_pkg.sv */
// Types shared by the fail-safe clock monitor modules.
// Assumes fsc_consts.svh supplies every numeric figure.
package fsc_pkg;

  // Controller states; the boot state launches the clock after reset
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_SLEEP,
    ST_STARTUP,
    ST_EXTERNAL,
    ST_FAILSAFE,
    ST_INTERNAL
  } fsc_state_e;

  // Register word
  typedef logic [15:0] fsc_word_t;

endpackage

/* File: fsc_detect_if.sv */
// Link between the clock controller and the fail detector.
// Assumes both ends run on the one system clock.
`timescale 1ns/10ps
interface fsc_detect_if;
  logic extFall;    // One-cycle pulse: external clock fell
  logic lfOsc;      // Sampled low-frequency oscillator level
  logic monitorOn;  // Detector armed
  logic failPulse;  // One-cycle pulse: failure seen
  logic sampleClk;  // Divided sample clock level

  // ----------------------------------------------------------------------
  // Controller end
  // ----------------------------------------------------------------------
  modport ctrl (output extFall, lfOsc, monitorOn, input failPulse, sampleClk);

  // ----------------------------------------------------------------------
  // Detector end
  // ----------------------------------------------------------------------
  modport det (input extFall, lfOsc, monitorOn, output failPulse, sampleClk);
endinterface

/* File: fsc_fail_detector.sv */
// Fail detector: divides the low-frequency oscillator into the sample clock
// and watches the latch that external falling edges set.
// Assumes its inputs are already sampled on the system clock.
`include "fsc_consts.svh"
`timescale 1ns/10ps
module fsc_fail_detector (
  input  wire logic   clock,
  input  wire logic   reset_n,
  fsc_detect_if.det   det
);
  logic       lfPrev_q, lfPrev_d;   // Previous oscillator level
  logic [5:0] divCnt_q, divCnt_d;   // Sample clock divider
  logic       latch_q,  latch_d;    // Edge-seen latch
  logic       fail_q,   fail_d;     // Failure pulse
  logic       lfRise;               // Oscillator rising edge
  logic       sampleRise;           // Sample clock rising edge
  logic       sampleFall;           // Sample clock falling edge

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    lfPrev_d   = det.lfOsc;
    lfRise     = det.lfOsc & ~lfPrev_q;
    divCnt_d   = lfRise ? divCnt_q + `FSC_DIV_STEP : divCnt_q;
    sampleRise = lfRise && (divCnt_q == `FSC_DIV_HALF);
    sampleFall = lfRise && (divCnt_q == `FSC_DIV_LAST);
    // Disarmed latch reads set, so arming never fakes a failure
    if (!det.monitorOn) begin
      latch_d = 1'b1;
    end else if (det.extFall) begin
      latch_d = 1'b1;
    end else if (sampleRise) begin
      latch_d = 1'b0;
    end else begin
      latch_d = latch_q;
    end
    // Whole high half passed with no external fall
    fail_d = det.monitorOn && sampleFall && !latch_q && !det.extFall;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lfPrev_q <= 1'b0;
      divCnt_q <= 6'h00;
      latch_q  <= 1'b1;
      fail_q   <= 1'b0;
    end else begin
      lfPrev_q <= lfPrev_d;
      divCnt_q <= divCnt_d;
      latch_q  <= latch_d;
      fail_q   <= fail_d;
    end
  end

  assign det.failPulse = fail_q;
  assign det.sampleClk = divCnt_q[5];
endmodule

/* File: fsc_monitor_properties.sv */
// Port-level checker for the fail-safe clock monitor top.
// Assumes one clock domain and the synchronous active-low reset.
`include "fsc_consts.svh"
`timescale 1ns/10ps
module fsc_monitor_properties (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        extClkIn,
  input wire logic        lfOscIn,
  input wire logic        sleepEnter,
  input wire logic        wakeDone,
  input wire logic [2:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic        sysClkInternal,
  input wire logic [3:0]  intFreqSel,
  input wire logic        cpuStall,
  input wire logic        failSafeActive,
  input wire logic        oscFailIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------------
  // Decoded register strobes
  // ----------------------------------------------------------------------
  wire ctlWr = regWrEn && (regAddr == `FSC_ADDR_CONTROL);  // Control write
  wire enWr  = regWrEn && (regAddr == `FSC_ADDR_ENABLES);  // Enable write

  // Outputs leave reset at their documented idle values
  property p_rst_vals;
    $rose(reset_n) |-> (regRdData == 16'h0000) && sysClkInternal && !failSafeActive
      && !oscFailIrq && !cpuStall && (intFreqSel == 4'h0);
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle after reset");
  // Fail-safe always runs from the internal source
  property p_fs_internal;
    failSafeActive |-> sysClkInternal;
  endproperty
  a_fs_internal: assert property (p_fs_internal) else $error("fail-safe on external");
  // A failure can only come from external running, never in start-up
  property p_fs_origin;
    $rose(failSafeActive) |-> $past(!sysClkInternal);
  endproperty
  a_fs_origin: assert property (p_fs_origin) else $error("failure outside external");
  // Condition drops only with a good switch, sleep or reset
  property p_fs_clear;
    $fell(failSafeActive) |-> !sysClkInternal || $past(sleepEnter) || $past(!reset_n);
  endproperty
  a_fs_clear: assert property (p_fs_clear) else $error("fail-safe dropped early");
  // Frequency select follows a control write in the next cycle
  property p_freq;
    ctlWr |=> intFreqSel == $past(regWrData[6:3]);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency select not updated");
  // Without a control write the frequency select holds
  property p_freq_hold;
    !ctlWr |=> $stable(intFreqSel);
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("frequency select moved");
  // Sleep clears the condition and leaves the internal source
  property p_sleep;
    sleepEnter |=> !failSafeActive && sysClkInternal;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not clear");
  // Clearing the enable silences the request
  property p_irq_mask;
    enWr && !regWrData[`FSC_EN_OSCFAIL] |=> !oscFailIrq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request raised");
  // A request rises only with a failure or a register write
  property p_irq_rise;
    $rose(oscFailIrq) |-> failSafeActive || $past(regWrEn);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("request without cause");
endmodule

/* File: fsc_ext_osc_model.sv */
// Model of the monitored external oscillator.
// Assumes the bench starts and stops it; a dead crystal freezes its level.
`timescale 1ns/10ps
module fsc_ext_osc_model #(
  parameter int HALF = 2  // System clocks per half period, keeps it below clock/2
) (
  input  wire logic clock,
  input  wire logic runEn,
  output logic      extClk
);
  int halfCnt_q;  // Cycles spent in the current half period

  initial begin
    extClk    = 1'b0;
    halfCnt_q = 0;
  end
  // Swing only while running; a stopped oscillator holds whatever level it had
  always @(posedge clock) begin
    if (runEn) begin
      halfCnt_q <= (halfCnt_q == HALF - 1) ? 0 : halfCnt_q + 1;
      if (halfCnt_q == HALF - 1) begin
        extClk <= ~extClk;
      end
    end
  end
endmodule

/* File: fail_safe_clock_monitor_tb.sv */
// Self-checking bench for the fail-safe clock monitor top.
// Assumes the oscillator model on the clock pin and the bound port checker.
`include "fsc_consts.svh"
`timescale 1ns/10ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module fail_safe_clock_monitor_tb;
  logic        clock, reset_n, extClkIn, lfOscIn, sleepEnter, wakeDone, runEn;
  logic        regWrEn, regRdEn, sysClkInternal, cpuStall, failSafeActive, oscFailIrq;
  logic [2:0]  regAddr;
  logic [15:0] regWrData, regRdData, rdVal;
  logic [3:0]  intFreqSel;
  logic [1:0]  lfCnt;  // Slow oscillator divider
  int          errCount, testsRun, waited;

  always #50 clock = ~clock;  // 10 MHz
  // Slow internal oscillator at a quarter of the clock
  always @(posedge clock) begin
    lfCnt   <= lfCnt + 2'h1;
    lfOscIn <= lfCnt[1];
  end

  fsc_fail_safe_monitor i_dut (.clock(clock), .reset_n(reset_n), .extClkIn(extClkIn),
    .lfOscIn(lfOscIn), .sleepEnter(sleepEnter), .wakeDone(wakeDone), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .sysClkInternal(sysClkInternal), .intFreqSel(intFreqSel), .cpuStall(cpuStall),
    .failSafeActive(failSafeActive), .oscFailIrq(oscFailIrq));
  fsc_ext_osc_model i_osc (.clock(clock), .runEn(runEn), .extClk(extClkIn));

  // ----------------------------------------------------------------------
  // Bus, pulse and wait helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", errCount, testsRun);
    if (errCount == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic osc(input logic on);
    @(posedge clock);
    runEn <= on;
  endtask
  task automatic pulse(input logic toSleep);
    @(posedge clock);
    sleepEnter <= toSleep;
    wakeDone   <= !toSleep;
    @(posedge clock);
    sleepEnter <= 1'b0;
    wakeDone   <= 1'b0;
    #1;
  endtask
  // Bounded wait: 0 internal source, 1 fail-safe, 2 stall
  task automatic waitSig(input int sel, input logic v, input int lim);
    waited = 0;
    while (((sel == 0) ? sysClkInternal : (sel == 1) ? failSafeActive : cpuStall) !== v) begin
      @(posedge clock);
      #1;
      waited++;
      if (waited > lim) begin
        errCount++;
        $display("unexpected at %0t: wait ran out", $time);
        report_and_stop();
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_boot();
    #1;
    `CHK(sysClkInternal, 1'b1)
    `CHK(cpuStall, 1'b0)
    rd(`FSC_ADDR_CONFIG);
    `CHK(rdVal, 16'h3002)
    rd(3'h5);
    `CHK(rdVal, 16'h0000)
    waitSig(0, 1'b0, 6000);
    `CHK(failSafeActive, 1'b0)
    rd(`FSC_ADDR_STATUS);
    `CHK(rdVal[`FSC_ST_OST_DONE], 1'b1)
  endtask
  // Frequency set ahead, then the crystal dies
  task automatic t_fail();
    wr(`FSC_ADDR_ENABLES, 16'h0080);
    wr(`FSC_ADDR_CONTROL, 16'h0050);
    #1;
    `CHK(intFreqSel, 4'hA)
    osc(1'b0);
    waitSig(1, 1'b1, 700);
    `CHK(sysClkInternal, 1'b1)
    `CHK(oscFailIrq, 1'b1)
    rd(`FSC_ADDR_FLAGS);
    `CHK(rdVal[`FSC_FLAG_OSCFAIL], 1'b1)
    repeat (300) @(posedge clock);
    #1;
    `CHK(sysClkInternal, 1'b1)
    wr(`FSC_ADDR_ENABLES, 16'h0000);
    @(posedge clock);
    #1;
    `CHK(oscFailIrq, 1'b0)
  endtask
  // Firmware clears the flag, restarts and reselects; then a second failure
  task automatic t_recover();
    wr(`FSC_ADDR_FLAGS, 16'h0000);
    wr(`FSC_ADDR_ENABLES, 16'h0080);
    osc(1'b1);
    wr(`FSC_ADDR_CONTROL, 16'h0051);
    repeat (20) @(posedge clock);
    #1;
    `CHK(sysClkInternal, 1'b1)
    `CHK(failSafeActive, 1'b1)
    waitSig(1, 1'b0, 6000);
    `CHK(sysClkInternal, 1'b0)
    osc(1'b0);
    waitSig(1, 1'b1, 700);
    `CHK(oscFailIrq, 1'b1)
  endtask
  // Sleep clears the condition; clock-input mode skips the timer
  task automatic t_sleep_ec();
    wr(`FSC_ADDR_CONTROL, 16'h0050);
    pulse(1'b1);
    `CHK(failSafeActive, 1'b0)
    `CHK(sysClkInternal, 1'b1)
    wr(`FSC_ADDR_FLAGS, 16'h0000);
    wr(`FSC_ADDR_CONFIG, 16'h3003);
    osc(1'b1);
    pulse(1'b0);
    waitSig(0, 1'b0, 20);
    osc(1'b0);
    waitSig(1, 1'b1, 700);
  endtask
  // Monitor and two-speed off: stall while starting, no detection
  task automatic t_disabled();
    pulse(1'b1);
    wr(`FSC_ADDR_CONFIG, 16'h0002);
    osc(1'b1);
    pulse(1'b0);
    repeat (5) @(posedge clock);
    #1;
    `CHK(cpuStall, 1'b1)
    waitSig(2, 1'b0, 6000);
    osc(1'b0);
    repeat (800) @(posedge clock);
    #1;
    `CHK(failSafeActive, 1'b0)
  endtask

  initial begin
    clock      = 1'b0;
    reset_n    = 1'b0;
    runEn      = 1'b1;
    lfCnt      = 2'h0;
    lfOscIn    = 1'b0;
    sleepEnter = 1'b0;
    wakeDone   = 1'b0;
    regWrEn    = 1'b0;
    regRdEn    = 1'b0;
    regAddr    = 3'h0;
    regWrData  = 16'h0000;
    errCount   = 0;
    testsRun   = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_boot();
    t_fail();
    t_recover();
    t_sleep_ec();
    t_disabled();
    report_and_stop();
  end
endmodule

bind fsc_fail_safe_monitor fsc_monitor_properties i_props (.clock(clock), .reset_n(reset_n),
  .extClkIn(extClkIn), .lfOscIn(lfOscIn), .sleepEnter(sleepEnter), .wakeDone(wakeDone),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .sysClkInternal(sysClkInternal), .intFreqSel(intFreqSel),
  .cpuStall(cpuStall), .failSafeActive(failSafeActive), .oscFailIrq(oscFailIrq));
